/* rtl/lbt_map.svh */
// lbt_map.svh: offsets, field positions, reset values and timing counts of the blink timer.
// assumes: included by the design files and the test; definitions only.
`ifndef LBT_MAP_SVH
`define LBT_MAP_SVH

// ----------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define LBT_IDX_ON   32'h0B000240
`define LBT_IDX_OFF  32'h0B000242
`define LBT_IDX_CTL  32'h0B000248
`define LBT_IDX_CNT  32'h0B00024A
`define LBT_IDX_FLAG 32'h0B00024C
`define LBT_IDX_MASK 32'h0B00024E

// ----------------------------------------------------------------------
// field positions and widths
// ----------------------------------------------------------------------
`define LBT_ON_W       5
`define LBT_OFF_W      7
`define LBT_CNT_W      16
`define LBT_CTL_EN_BIT 0
`define LBT_CTL_ST_BIT 1
`define LBT_FLAG_BIT   0

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define LBT_ON_RST   5'h10
`define LBT_OFF_RST  7'h20
`define LBT_EN_RST   1'b0
`define LBT_ST_RST   1'b1
`define LBT_CNT_RST  16'h04B0
`define LBT_MASK_RST 1'b0

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define LBT_CLK_NS   25
`define LBT_STEP_NS  62500000
`define LBT_TICK_CYC (`LBT_STEP_NS / `LBT_CLK_NS)

`endif

/* rtl/lbt_pkg.sv */
// lbt_pkg: types shared by the blink timer files.
// assumes: lbt_map.svh supplies the numeric constants.
package lbt_pkg;

  // gray order along idle -> on -> off
  typedef enum logic [1:0] {
    LBT_IDLE = 2'b00,
    LBT_ON   = 2'b01,
    LBT_OFF  = 2'b11
  } lbt_state_t;

  typedef enum logic [2:0] {
    LBT_R_NONE,
    LBT_R_ON,
    LBT_R_OFF,
    LBT_R_CTL,
    LBT_R_CNT,
    LBT_R_FLAG,
    LBT_R_MASK
  } lbt_reg_t;

  // ahb address phase held into the data phase
  typedef struct packed {
    logic valid;
    logic write;
    lbt_reg_t sel;
  } lbt_aphase_t;

endpackage : lbt_pkg

/* rtl/lbt_tick_gen.sv */
// lbt_tick_gen: divides ref_clk down to the 0.0625 s step tick.
// assumes: ref_clk is the always-on timebase; clear holds the divider at zero.
`timescale 1ns/1ps
`include "lbt_map.svh"

module lbt_tick_gen #(
  parameter int CYCLES = `LBT_TICK_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clear,
  output logic tick
);
  localparam int CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;

  always_comb begin
    tick = 1'b0;
    cnt_d = cnt_q + CW'(1);
    if (clear) begin
      cnt_d = '0;
    end else if (cnt_q == CW'(CYCLES - 1)) begin
      tick = 1'b1;
      cnt_d = '0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  property p_tick_clear;
    @(posedge ref_clk) disable iff (!rst_n) clear |-> !tick;
  endproperty
  a_tick_clear: assert property (p_tick_clear) else $error("tick while divider cleared");

endmodule : lbt_tick_gen

/* rtl/lbt_top.sv */
// lbt_top: indicator blink timer with ahb-lite register access.
// assumes: ref_clk is the always-on 40 MHz timebase, rst_n is the rtc-domain reset,
// soft_reset is a one-cycle pulse from logic on ref_clk for all other resets.
`timescale 1ns/1ps
`include "lbt_map.svh"

// Functional notes
// - blink alternates on and off while enabled
// - runs on always-on clock through low-power modes
// - on duration five bits, steps, zero forbidden
// - on phase drives output high
// - rtc reset loads one-second on duration
// - off duration seven bits, steps, zero forbidden
// - off phase drives output low
// - rtc reset loads two-second off duration
// - other resets keep duration settings
// - unused upper bits read zero
// - control holds enable and auto-stop bits
// - pair countdown from 1200 raises event; the code sets the event flag only when the auto-stop bit is set
// - auto-stop event clears both enable bits
// - event flag cleared by writing one
module lbt_top
  import lbt_pkg::*;
#(
  parameter int TICK_CYCLES = `LBT_TICK_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic soft_reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic indicator_out_n,
  output logic irq
);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  lbt_aphase_t aph_q, aph_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic [15:0] rd_mux;
  logic wr;

  logic [`LBT_ON_W-1:0] on_dur_q, on_dur_d;
  logic [`LBT_OFF_W-1:0] off_dur_q, off_dur_d;
  logic en_q, en_d;
  logic stop_q, stop_d;
  logic [`LBT_CNT_W-1:0] cnt_set_q, cnt_set_d;
  logic flag_q, flag_d;
  logic mask_q, mask_d;

  lbt_state_t state_q, state_d;
  logic [6:0] phase_q, phase_d;
  logic [6:0] phase_inc;
  logic [`LBT_CNT_W-1:0] remain_q, remain_d;
  logic out_q, out_d;
  logic tick;
  logic pair_done;
  logic auto_stop;

  function automatic lbt_reg_t decode(input logic [31:0] a);
    logic [29:0] w;
    w = a[31:2];
    case (w)
      30'(`LBT_IDX_ON): decode = LBT_R_ON;
      30'(`LBT_IDX_OFF): decode = LBT_R_OFF;
      30'(`LBT_IDX_CTL): decode = LBT_R_CTL;
      30'(`LBT_IDX_CNT): decode = LBT_R_CNT;
      30'(`LBT_IDX_FLAG): decode = LBT_R_FLAG;
      30'(`LBT_IDX_MASK): decode = LBT_R_MASK;
      default: decode = LBT_R_NONE;
    endcase
  endfunction : decode

  // ----------------------------------------------------------------------
  // ahb-lite slave
  // ----------------------------------------------------------------------
  // reads take one wait state so a read right behind a write sees the new value
  always_comb begin
    aph_d = '0;
    if (hsel && hready && htrans[1]) begin
      aph_d.valid = 1'b1;
      aph_d.write = hwrite;
      aph_d.sel = decode(haddr);
    end
    case (aph_q.sel)
      LBT_R_ON: rd_mux = {11'h000, on_dur_q};
      LBT_R_OFF: rd_mux = {9'h000, off_dur_q};
      LBT_R_CTL: rd_mux = {14'h0000, stop_q, en_q};
      LBT_R_CNT: rd_mux = cnt_set_q;
      LBT_R_FLAG: rd_mux = {15'h0000, flag_q};
      LBT_R_MASK: rd_mux = {15'h0000, mask_q};
      default: rd_mux = 16'h0000;
    endcase
    hrdata_d = hrdata_q;
    if (aph_q.valid && !aph_q.write) begin
      hrdata_d = {16'h0000, rd_mux};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      aph_q <= '0;
      hrdata_q <= 32'h00000000;
    end else begin
      aph_q <= aph_d;
      hrdata_q <= hrdata_d;
    end
  end

  assign hreadyout = !(aph_q.valid && !aph_q.write);
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign wr = aph_q.valid && aph_q.write;

  // ----------------------------------------------------------------------
  // step tick
  // ----------------------------------------------------------------------
  // one clock, never gated, so blinking survives every low-power mode
  lbt_tick_gen #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clear(state_q == LBT_IDLE),
    .tick(tick)
  );

  // ----------------------------------------------------------------------
  // blink sequencer
  // ----------------------------------------------------------------------
  // zero durations are forbidden; a zero here runs 128 steps, not defined behaviour
  always_comb begin
    state_d = state_q;
    phase_d = en_q ? phase_q : 7'h00;
    remain_d = remain_q;
    pair_done = 1'b0;
    auto_stop = 1'b0;
    phase_inc = phase_q + 7'h01;
    case (state_q)
      LBT_IDLE: begin
        phase_d = 7'h00;
        if (en_q) begin
          state_d = LBT_ON;
          remain_d = cnt_set_q;
        end
      end
      LBT_ON: begin
        if (!en_q) begin
          state_d = LBT_IDLE;
        end else if (tick) begin
          phase_d = phase_inc;
          if (phase_inc == {2'b00, on_dur_q}) begin
            state_d = LBT_OFF;
            phase_d = 7'h00;
          end
        end
      end
      LBT_OFF: begin
        if (!en_q) begin
          state_d = LBT_IDLE;
        end else if (tick) begin
          phase_d = phase_inc;
          if (phase_inc == off_dur_q) begin
            state_d = LBT_ON;
            phase_d = 7'h00;
            pair_done = 1'b1;
          end
        end
      end
      default: begin
        state_d = LBT_IDLE;
        phase_d = 7'h00;
      end
    endcase
    if (pair_done) begin
      remain_d = remain_q - 16'h0001;
      if (remain_q == 16'h0001) begin
        remain_d = cnt_set_q;
        if (stop_q) begin
          auto_stop = 1'b1;
          state_d = LBT_IDLE;
        end
      end
    end
    out_d = (state_d == LBT_ON);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= LBT_IDLE;
      phase_q <= 7'h00;
      remain_q <= `LBT_CNT_RST;
      out_q <= 1'b0;
    end else begin
      state_q <= state_d;
      phase_q <= phase_d;
      remain_q <= remain_d;
      out_q <= out_d;
    end
  end

  assign indicator_out_n = out_q;

  // ----------------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------------
  always_comb begin
    on_dur_d = on_dur_q;
    off_dur_d = off_dur_q;
    en_d = en_q;
    stop_d = stop_q;
    cnt_set_d = cnt_set_q;
    flag_d = flag_q;
    mask_d = mask_q;
    if (wr) begin
      case (aph_q.sel)
        LBT_R_ON: on_dur_d = hwdata[`LBT_ON_W-1:0];
        LBT_R_OFF: off_dur_d = hwdata[`LBT_OFF_W-1:0];
        LBT_R_CTL: begin
          en_d = hwdata[`LBT_CTL_EN_BIT];
          stop_d = hwdata[`LBT_CTL_ST_BIT];
        end
        LBT_R_CNT: cnt_set_d = hwdata[`LBT_CNT_W-1:0];
        LBT_R_FLAG: begin
          if (hwdata[`LBT_FLAG_BIT]) begin
            flag_d = 1'b0;
          end
        end
        LBT_R_MASK: mask_d = hwdata[0];
        default: ;
      endcase
    end
    // durations and control survive the other resets
    if (soft_reset) begin
      cnt_set_d = `LBT_CNT_RST;
      flag_d = 1'b0;
      mask_d = `LBT_MASK_RST;
    end
    // the hardware event wins over a same-cycle clear or re-enable
    if (auto_stop) begin
      en_d = 1'b0;
      stop_d = 1'b0;
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      on_dur_q <= `LBT_ON_RST;
      off_dur_q <= `LBT_OFF_RST;
      en_q <= `LBT_EN_RST;
      stop_q <= `LBT_ST_RST;
      cnt_set_q <= `LBT_CNT_RST;
      flag_q <= 1'b0;
      mask_q <= `LBT_MASK_RST;
    end else begin
      on_dur_q <= on_dur_d;
      off_dur_q <= off_dur_d;
      en_q <= en_d;
      stop_q <= stop_d;
      cnt_set_q <= cnt_set_d;
      flag_q <= flag_d;
      mask_q <= mask_d;
    end
  end

  assign irq = flag_q && mask_q;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  property p_on_level;
    (state_q == LBT_ON) |-> indicator_out_n;
  endproperty
  a_on_level: assert property (p_on_level) else $error("output low in on phase");

  property p_off_level;
    (state_q != LBT_ON) |-> !indicator_out_n;
  endproperty
  a_off_level: assert property (p_off_level) else $error("output high outside on");

  property p_disable;
    (!en_q && state_q != LBT_IDLE) |=> (state_q == LBT_IDLE) && (phase_q == 7'h00);
  endproperty
  a_disable: assert property (p_disable) else $error("sequencer kept running");

  property p_start_on;
    (state_q == LBT_IDLE && en_q) |=> (state_q == LBT_ON) && indicator_out_n;
  endproperty
  a_start_on: assert property (p_start_on) else $error("blink did not start on");

  property p_on_len;
    (state_q == LBT_ON && en_q && tick && phase_q == 7'({2'b00, on_dur_q} - 7'h01))
      |=> (state_q == LBT_OFF);
  endproperty
  a_on_len: assert property (p_on_len) else $error("on phase wrong length");

  property p_on_hold;
    (state_q == LBT_ON && !tick && en_q) |=> (state_q == LBT_ON);
  endproperty
  a_on_hold: assert property (p_on_hold) else $error("phase left without tick");

  sequence s_last_pair;
    pair_done && remain_q == 16'h0001 && stop_q && en_q;
  endsequence
  sequence s_stopped;
    !en_q && !stop_q && flag_q ##1 (state_q == LBT_IDLE) && !indicator_out_n;
  endsequence
  property p_autostop;
    s_last_pair |=> s_stopped;
  endproperty
  a_autostop: assert property (p_autostop) else $error("auto stop missed");

  property p_flag_sticky;
    (flag_q && !soft_reset && !(wr && aph_q.sel == LBT_R_FLAG && hwdata[0])) |=> flag_q;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost");

  property p_irq;
    (flag_q && mask_q) |-> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq not raised");

  property p_soft_keep;
    soft_reset && !wr |=> (on_dur_q == $past(on_dur_q)) && (off_dur_q == $past(off_dur_q));
  endproperty
  a_soft_keep: assert property (p_soft_keep) else $error("duration lost on reset");

  property p_read_zero;
    (aph_d.valid && !aph_d.write && aph_d.sel == LBT_R_ON && !wr)
      |=> !hreadyout ##1 (hreadyout && hrdata[31:5] == 27'h0);
  endproperty
  a_read_zero: assert property (p_read_zero) else $error("upper bits not zero");

endmodule : lbt_top

/* tb/lbt_led_model.sv */
// lbt_led_model: indicator lamp hanging on indicator_out_n, timing each lit and dark phase.
// assumes: sampled on rising ref_clk; clear restarts all measurements.
`timescale 1ns/1ps

module lbt_led_model (
  input wire logic ref_clk,
  input wire logic indicator_out_n,
  input wire logic clear,
  output int pulses,
  output int on_cyc,
  output int off_cyc
);
  logic prev_q = 1'b0;
  int run_q = 0;

  // a width is only known once the level flips, so the dark phase that ends in a stop is not recorded
  always @(posedge ref_clk) begin
    prev_q <= indicator_out_n;
    if (clear) begin
      pulses <= 0;
      on_cyc <= 0;
      off_cyc <= 0;
      run_q <= 0;
    end else if (indicator_out_n !== prev_q) begin
      if (prev_q === 1'b1) begin
        on_cyc <= run_q;
      end else if (pulses > 0) begin
        off_cyc <= run_q;
      end
      if (indicator_out_n === 1'b1) begin
        pulses <= pulses + 1;
      end
      run_q <= 1;
    end else begin
      run_q <= run_q + 1;
    end
  end
endmodule : lbt_led_model

/* tb/led_blink_timer_test.sv */
// led_blink_timer_test: register tests and blink timing of lbt_top over ahb-lite.
// assumes: one slave, so hready is the design's hreadyout; tick shortened to 4 cycles.
`timescale 1ns/1ps
`include "lbt_map.svh"

module led_blink_timer_test;
  localparam int T = 4;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic soft_reset = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hready;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic indicator_out_n;
  logic irq;
  logic clear = 1'b1;
  int pulses;
  int on_cyc;
  int off_cyc;
  int fail_count = 0;
  int num_checks = 0;

  assign hready = hreadyout;
  always #12.5 ref_clk = ~ref_clk;

  lbt_top #(.TICK_CYCLES(T)) i_dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .soft_reset(soft_reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .indicator_out_n(indicator_out_n), .irq(irq));

  lbt_led_model i_led (.ref_clk(ref_clk), .indicator_out_n(indicator_out_n), .clear(clear),
    .pulses(pulses), .on_cyc(on_cyc), .off_cyc(off_cyc));

  // ----------------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // waits for hready high at a rising edge, bounded
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1) begin
      fail_count++;
      $display("[FAIL] %0t bus hang", $time);
      give_verdict();
    end
  endtask : wait_ready

  task automatic bus(input logic wr, input logic [31:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= idx << 2;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask : bus

  task automatic wr(input logic [31:0] idx, input logic [31:0] wd);
    logic [31:0] r;
    bus(1'b1, idx, wd, r);
    // the register lands on the closing edge; let it settle before anyone looks
    @(negedge ref_clk);
  endtask : wr

  task automatic rd(input logic [31:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, idx, 32'h0, r);
    chk(r, exp);
  endtask : rd

  task automatic cycles(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cycles

  task automatic defaults();
    rd(`LBT_IDX_ON, 32'h00000010);
    rd(`LBT_IDX_OFF, 32'h00000020);
    rd(`LBT_IDX_CTL, 32'h00000002);
    rd(`LBT_IDX_CNT, 32'h000004B0);
    rd(`LBT_IDX_FLAG, 32'h00000000);
    rd(`LBT_IDX_MASK, 32'h00000000);
    rd(32'h0B000244, 32'h00000000);
    chk({31'h0, indicator_out_n}, 32'h0);
  endtask : defaults

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    int n;
    cycles(16);
    rst_n <= 1'b1;
    clear <= 1'b0;
    defaults();
    $display("test reset values done");

    wr(`LBT_IDX_ON, 32'h0000001F);
    wr(`LBT_IDX_OFF, 32'h0000007F);
    rd(`LBT_IDX_ON, 32'h0000001F);
    rd(`LBT_IDX_OFF, 32'h0000007F);
    wr(`LBT_IDX_CNT, 32'h00000002);
    wr(`LBT_IDX_MASK, 32'h00000001);
    wr(`LBT_IDX_CTL, 32'h00000003);
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 3000) begin
      fail_count++;
      $display("[FAIL] %0t no auto-stop event", $time);
      give_verdict();
    end
    cycles(2);
    chk(pulses, 2);
    chk(on_cyc, 32'h1F * T);
    chk(off_cyc, 32'h7F * T);
    chk({31'h0, indicator_out_n}, 32'h0);
    rd(`LBT_IDX_CTL, 32'h00000000);
    rd(`LBT_IDX_FLAG, 32'h00000001);
    rd(`LBT_IDX_CNT, 32'h00000002);
    wr(`LBT_IDX_MASK, 32'h00000000);
    chk({31'h0, irq}, 32'h0);
    wr(`LBT_IDX_MASK, 32'h00000001);
    chk({31'h0, irq}, 32'h1);
    wr(`LBT_IDX_FLAG, 32'h00000001);
    chk({31'h0, irq}, 32'h0);
    rd(`LBT_IDX_FLAG, 32'h00000000);
    $display("test auto-stop done");

    clear <= 1'b1;
    wr(`LBT_IDX_ON, 32'h00000001);
    wr(`LBT_IDX_OFF, 32'h00000001);
    wr(`LBT_IDX_CNT, 32'h00000001);
    clear <= 1'b0;
    wr(`LBT_IDX_CTL, 32'h00000001);
    cycles(60);
    chk({31'h0, pulses >= 6}, 32'h1);
    chk(on_cyc, T);
    chk(off_cyc, T);
    rd(`LBT_IDX_FLAG, 32'h00000000);
    wr(`LBT_IDX_CTL, 32'h00000000);
    cycles(2);
    chk({31'h0, indicator_out_n}, 32'h0);
    $display("test free running done");

    @(posedge ref_clk);
    soft_reset <= 1'b1;
    @(posedge ref_clk);
    soft_reset <= 1'b0;
    rd(`LBT_IDX_ON, 32'h00000001);
    rd(`LBT_IDX_OFF, 32'h00000001);
    rd(`LBT_IDX_CTL, 32'h00000000);
    rd(`LBT_IDX_CNT, 32'h000004B0);
    rd(`LBT_IDX_MASK, 32'h00000000);
    $display("test other reset done");

    @(posedge ref_clk);
    rst_n <= 1'b0;
    cycles(2);
    rst_n <= 1'b1;
    defaults();
    $display("test second rtc reset done");
    give_verdict();
  end
endmodule : led_blink_timer_test
